// file: testbench/plsr_board.sv
// Board model: strap resistors, config pins, outside reset source.
// Assumes the bench changes straps only around a reset pulse.
`timescale 1ns/1ps
module plsr_board #(
  parameter int HOLD = 20
) (
  input  wire logic       core_clk,
  input  wire logic       rstReq,
  input  wire logic [8:0] straps,
  output logic            resetPinN,
  output logic            configPinA,
  output logic            configPinB,
  output logic            multifunctionStrapA,
  output logic [4:0]      ledStrapIn
);
  int cnt = 0;
  always @(posedge core_clk) begin
    if (rstReq) cnt <= HOLD;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign resetPinN = (cnt == 0);
  assign {multifunctionStrapA, configPinB, configPinA} = straps[8:6];
  assign ledStrapIn = straps[4:0];
endmodule

// file: testbench/plsr_ctrl_chk.sv
// Port checker for plsr_ctrl: LEDs, reset, power-down, bus wait.
// Assumes binding to every plsr_ctrl instance.
`timescale 1ns/1ps
module plsr_ctrl_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic resetDone,
  input wire logic powerDown,
  input wire logic ledOe,
  input wire logic lineTxOe,
  input wire logic miiIsolate,
  input wire logic speed100,
  input wire logic speedLowLed,
  input wire logic speedHighLed,
  input wire logic fullDuplex,
  input wire logic duplexLed,
  input wire logic linkGood,
  input wire logic linkLed,
  input wire logic txActive,
  input wire logic rxActive,
  input wire logic activityLed
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_speed_high:
    assert property ((resetDone && !powerDown && speed100)[*4] |-> speedHighLed && !speedLowLed)
    else $error("speed high LED wrong");
  a_speed_low:
    assert property ((resetDone && !powerDown && !speed100)[*4] |-> speedLowLed && !speedHighLed)
    else $error("speed low LED wrong");
  a_duplex_full:
    assert property ((resetDone && !powerDown && fullDuplex)[*4] |-> duplexLed)
    else $error("duplex LED not steady");
  a_link_off:
    assert property ((!linkGood)[*4] |-> !linkLed)
    else $error("link LED on without link");
  a_act_idle:
    assert property ((!txActive && !rxActive)[*4] |-> !activityLed)
    else $error("activity LED on while idle");
  a_pd_off:
    assert property (powerDown [*2] |-> !ledOe && !lineTxOe && miiIsolate)
    else $error("outputs driven in power-down");
  a_busy_reset:
    assert property (!resetDone |-> avs_waitrequest && !ledOe && miiIsolate)
    else $error("usable before reset done");
  a_ack_next:
    assert property ($rose(avs_read) && resetDone |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
endmodule

bind plsr_ctrl plsr_ctrl_chk i_plsr_ctrl_chk (.*);

// file: testbench/testbench.sv
// Self-checking bench for plsr_ctrl with a board model.
// Assumes shortened internal reset and blink counts.
`timescale 1ns/1ps
module testbench;
  localparam int RC = 20;
  localparam int AH = 16;
  logic core_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, cv;
  logic avs_waitrequest, powerDownPin = 1'b0, rstReq = 1'b0;
  logic speed100 = 1'b0, linkGood = 1'b0, txActive = 1'b0, rxActive = 1'b0;
  logic fullDuplex = 1'b0, collision = 1'b0;
  logic [8:0] straps;
  logic resetPinN, configPinA, configPinB, multifunctionStrapA;
  logic [4:0] ledStrapIn;
  logic speedLowLed, speedHighLed, activityLed, linkLed, duplexLed, ledOe, lineTxOe;
  logic miiIsolate, resetDone, autonegEnable, lineCodeBypass, loopback, powerDown;
  logic [1:0] advertiseMode;
  int fail_count = 0, num_checks = 0, seed = 68, n;
  logic [2:0] prv, cur;
  int rise [3];
  always #12.5 core_clk = ~core_clk;
  plsr_ctrl #(.RESET_CYCLES(RC), .ACT_HALF_CYCLES(AH),
              .COL_HALF_CYCLES(AH / 2)) i_plsr_ctrl (.*);
  plsr_board #(.HOLD(RC)) i_plsr_board (.*);
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task bus(input bit w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge core_clk);
    {avs_address, avs_writedata, avs_byteenable} <= {a, d, be};
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 400);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      final_report;
    end
  endtask
  task pd(input logic e);
    repeat (6) @(negedge core_clk);
    chk("pdOuts", 32'({e, !e, !e, e}), 32'({powerDown, ledOe, lineTxOe, miiIsolate}));
  endtask
  initial begin
    straps = 9'($random(seed));
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i > 0) begin
        @(posedge core_clk);
        straps <= 9'($random(seed));
        rstReq <= 1'b1;
        @(posedge core_clk);
        rstReq <= 1'b0;
        repeat (6) @(negedge core_clk);
        chk("doneLow", 32'h0, 32'(resetDone));
      end
      n = 0;
      do @(negedge core_clk); while (resetDone !== 1'b1 && ++n < 400);
      if (n >= 400) begin
        fail_count++;
        final_report;
      end
      chk("doneTime", 32'h1, 32'(n > RC && n <= (i > 0 ? 2 * RC + 8 : RC + 8)));
      bus(0, 4'h4, 32'h0, 4'hf);
      chk("strap", 32'({straps[4:0], 3'h0}), q);
      bus(0, 4'h8, 32'h0, 4'hf);
      chk("status", straps[8] ? 32'h20 | 32'(straps[7:6]) : 32'h20, q);
      bus(0, 4'h0, 32'h0, 4'hf);
      cv = straps[8] ? 32'h1000 : 32'({straps[7], 12'h0, straps[6], 1'b0});
      chk("ctrl", cv, q & (straps[8] ? 32'hffffbffd : 32'hffffffff));
      chk("modePins", 32'({straps[8], cv[14], cv[1], straps[8] ? straps[7:6] : 2'h0}),
          32'({autonegEnable, loopback, lineCodeBypass, advertiseMode}));
    end
    bus(1, 4'hc, 32'hffffffff, 4'hf);
    bus(0, 4'hc, 32'h0, 4'hf);
    chk("unmapped", 32'h0, q);
    bus(1, 4'h4, 32'h0, 4'hf);
    bus(0, 4'h4, 32'h0, 4'hf);
    chk("strapRo", 32'({straps[4:0], 3'h0}), q);
    bus(0, 4'h0, 32'h0, 4'hf);
    cv = q;
    bus(1, 4'h0, cv | 32'h800, 4'h1);
    pd(1'b0);
    bus(1, 4'h0, cv | 32'h800, 4'h2);
    pd(1'b1);
    bus(0, 4'h8, 32'h0, 4'hf);
    chk("statusPd", 32'h1, 32'(q[4]));
    bus(1, 4'h0, cv, 4'hf);
    pd(1'b0);
    @(posedge core_clk);
    powerDownPin <= 1'b1;
    pd(1'b1);
    @(posedge core_clk);
    powerDownPin <= 1'b0;
    pd(1'b0);
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk);
      {speed100, linkGood, fullDuplex, txActive, rxActive, collision} <= 6'($random(seed));
      repeat (6) @(negedge core_clk);
      chk("speed", 32'({speed100, !speed100}), 32'({speedHighLed, speedLowLed}));
      if (!txActive && !rxActive) chk("idle", 32'({linkGood, 1'b0}), 32'({linkLed, activityLed}));
      if (fullDuplex || !collision) chk("duplex", 32'(fullDuplex), 32'(duplexLed));
    end
    // Four activity half periods: two activity blinks, four collision blinks
    @(posedge core_clk);
    {speed100, linkGood, fullDuplex, txActive, rxActive, collision} <= 6'h15;
    repeat (6) @(negedge core_clk);
    prv = {activityLed, linkLed, duplexLed};
    rise = '{0, 0, 0};
    for (int i = 0; i < 4 * AH; i++) begin
      @(negedge core_clk);
      cur = {activityLed, linkLed, duplexLed};
      for (int j = 0; j < 3; j++) begin
        if (cur[j] && !prv[j]) rise[j]++;
      end
      prv = cur;
    end
    chk("actRise", 32'h2, 32'(rise[2]));
    chk("linkRise", 32'h2, 32'(rise[1]));
    chk("colRise", 32'h4, 32'(rise[0]));
    final_report;
  end
endmodule

// file: verilog/plsr_blink.sv
// Free-running divider producing a square blink pattern.
// Assumes a single core clock; the half period is given in cycles.
`timescale 1ns/1ps
module plsr_blink #(
  parameter int unsigned HALF_CYCLES = 2
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  output logic      blink
);

  localparam int unsigned CW = $clog2(HALF_CYCLES + 1);

  logic [CW-1:0] count;
  wire           wrap;
  wire  [CW-1:0] next_count;

  assign wrap       = (count == CW'(HALF_CYCLES - 1));
  assign next_count = wrap ? '0 : count + CW'(1);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      blink <= 1'b0;
    end else begin
      count <= next_count;
      if (wrap) begin
        blink <= ~blink;
      end
    end
  end

endmodule

// file: verilog/plsr_ctrl.sv
// LED, strap, configuration-pin, reset and power-down control of the transceiver.
// Assumes one 40 MHz clock; pins are asynchronous and synchronised here.
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module plsr_ctrl #(
  parameter int unsigned RESET_CYCLES    = plsr_pkg::RESET_CYCLES,
  parameter int unsigned ACT_HALF_CYCLES = plsr_pkg::ACT_HALF_CYCLES,
  parameter int unsigned COL_HALF_CYCLES = plsr_pkg::COL_HALF_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Pins and link status
  input  wire logic        resetPinN,
  input  wire logic        powerDownPin,
  input  wire logic        configPinA,
  input  wire logic        configPinB,
  input  wire logic        multifunctionStrapA,
  input  wire logic [4:0]  ledStrapIn,
  input  wire logic        speed100,
  input  wire logic        linkGood,
  input  wire logic        txActive,
  input  wire logic        rxActive,
  input  wire logic        fullDuplex,
  input  wire logic        collision,
  // Outputs
  output logic             speedLowLed,
  output logic             speedHighLed,
  output logic             activityLed,
  output logic             linkLed,
  output logic             duplexLed,
  output logic             ledOe,
  output logic             lineTxOe,
  output logic             miiIsolate,
  output logic             resetDone,
  output logic             autonegEnable,
  output logic             lineCodeBypass,
  output logic             loopback,
  output logic             powerDown,
  output logic [1:0]       advertiseMode
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int unsigned NSYNC = 16;

  logic [NSYNC-1:0] syncA;
  logic [NSYNC-1:0] syncB;
  wire  [NSYNC-1:0] pinsIn;

  assign pinsIn = {resetPinN, powerDownPin, configPinA, configPinB, multifunctionStrapA,
                   ledStrapIn, speed100, linkGood, txActive, rxActive, fullDuplex, collision};

  // Only the second stage feeds any logic
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= pinsIn;
      syncB <= syncA;
    end
  end

  wire       sResetN    = syncB[15];
  wire       sPwrPin    = syncB[14];
  wire       sCfgA      = syncB[13];
  wire       sCfgB      = syncB[12];
  wire       sMfA       = syncB[11];
  wire [4:0] sStraps    = syncB[10:6];
  wire       sSpeed100  = syncB[5];
  wire       sLinkGood  = syncB[4];
  wire       sTx        = syncB[3];
  wire       sRx        = syncB[2];
  wire       sFull      = syncB[1];
  wire       sCol       = syncB[0];

  // ****************************************
  // Reset sequencer
  // ****************************************
  typedef enum logic [1:0] {
    ST_RESET = 2'b01,
    ST_READY = 2'b10
  } plsr_state_t;

  localparam int unsigned RW = $clog2(RESET_CYCLES + 1);

  plsr_state_t   state;
  plsr_state_t   next_state;
  logic [RW-1:0] rstCount;
  wire           rstExpired;
  wire           inReset;

  assign rstExpired = (rstCount == RW'(RESET_CYCLES - 1));
  assign inReset    = (state != ST_READY);

  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (sResetN && rstExpired) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        if (!sResetN) begin
          next_state = ST_RESET;
        end
      end
      default: next_state = ST_RESET;
    endcase
  end

  // Count restarts whenever the reset pin is seen low again
  // Power-up reset timer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state    <= ST_RESET;
      rstCount <= '0;
    end else begin
      state <= next_state;
      if (!sResetN || state == ST_READY) begin
        rstCount <= '0;
      end else if (!rstExpired) begin
        rstCount <= rstCount + RW'(1);
      end
    end
  end

  // ****************************************
  // Strap capture and control register
  // ****************************************
  logic [4:0]  strapLatch;
  logic [31:0] ctrlReg;
  wire         busSel;
  wire         wrCtrl;
  wire         wrAccess;
  logic        ack;

  assign busSel   = (avs_read || avs_write) && !inReset;
  assign wrAccess = avs_write && !inReset;
  // Write lands once, on the edge where waitrequest is low
  assign wrCtrl   = wrAccess && ack && (avs_address == plsr_pkg::CTRL_OFFSET);

  function automatic logic [31:0] merge_bytes(input logic [31:0] oldV, input logic [31:0] newV,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = oldV;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return r;
  endfunction

  wire [31:0] ctrlWritten = merge_bytes(ctrlReg, avs_writedata, avs_byteenable);

  // Bypass from pin A when autonegotiation is off
  wire pinBypass   = sMfA ? 1'b0 : sCfgA;
  // Loopback from pin B when autonegotiation is off
  wire pinLoopback = sMfA ? 1'b0 : sCfgB;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strapLatch <= '0;
    end else if (inReset) begin
      strapLatch <= sStraps;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrlReg <= plsr_pkg::CTRL_RESET;
    end else if (inReset) begin
      ctrlReg <= plsr_pkg::CTRL_RESET;
      ctrlReg[plsr_pkg::AUTONEG_BIT] <= sMfA;
      ctrlReg[plsr_pkg::BYPASS_BIT] <= pinBypass;
      ctrlReg[plsr_pkg::LOOPBACK_BIT] <= pinLoopback;
    end else if (wrCtrl) begin
      ctrlReg <= ctrlWritten;
    end
  end

  // ****************************************
  // Register read path
  // ****************************************
  wire [31:0] strapWord;
  wire [31:0] statusWord;
  wire [31:0] ctrlWord;
  wire [31:0] readMux;

  assign ctrlWord  = {17'h00000, ctrlReg[plsr_pkg::LOOPBACK_BIT], 1'b0,
                      ctrlReg[plsr_pkg::AUTONEG_BIT], ctrlReg[plsr_pkg::POWER_DOWN_BIT],
                      9'h000, ctrlReg[plsr_pkg::BYPASS_BIT], 1'b0};
  assign strapWord = {24'h000000, strapLatch, 3'h0};
  assign statusWord = {26'h0000000, resetDone, powerDown, 2'h0, advertiseMode};
  assign readMux   = (avs_address == plsr_pkg::CTRL_OFFSET)   ? ctrlWord  :
                     (avs_address == plsr_pkg::STRAP_OFFSET)  ? strapWord :
                     (avs_address == plsr_pkg::STATUS_OFFSET) ? statusWord : 32'h00000000;

  // Waitrequest drops for one cycle per access; held high while reset is in progress
  wire  next_ack = busSel && !ack;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack             <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      ack             <= next_ack;
      avs_waitrequest <= !next_ack;
      if (next_ack && avs_read) begin
        avs_readdata <= readMux;
      end
    end
  end

  // ****************************************
  // LED patterns
  // ****************************************
  wire actBlink;
  wire colBlink;

  // Dividers run free, so blink phase does not follow activity
  plsr_blink #(
    .HALF_CYCLES(ACT_HALF_CYCLES)
  ) u_act_blink (
    .core_clk (core_clk),
    .nrst     (nrst),
    .blink    (actBlink)
  );

  plsr_blink #(
    .HALF_CYCLES(COL_HALF_CYCLES)
  ) u_col_blink (
    .core_clk (core_clk),
    .nrst     (nrst),
    .blink    (colBlink)
  );

  wire active = sTx || sRx;
  wire pdNow = sPwrPin || ctrlReg[plsr_pkg::POWER_DOWN_BIT];
  wire [1:0] advNow = ctrlReg[plsr_pkg::AUTONEG_BIT] ? {sCfgB, sCfgA} : 2'b00;

  wire next_speedLowLed;
  wire next_speedHighLed;
  wire next_activityLed;
  wire next_linkLed;
  wire next_duplexLed;

  assign next_speedLowLed  = !sSpeed100;
  assign next_speedHighLed = sSpeed100;
  assign next_activityLed  = active && actBlink;
  assign next_linkLed      = sLinkGood && (active ? actBlink : 1'b1);
  assign next_duplexLed    = sFull || (sCol && colBlink);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      speedLowLed  <= 1'b0;
      speedHighLed <= 1'b0;
      activityLed  <= 1'b0;
      linkLed      <= 1'b0;
      duplexLed    <= 1'b0;
    end else begin
      speedLowLed  <= next_speedLowLed;
      speedHighLed <= next_speedHighLed;
      activityLed  <= next_activityLed;
      linkLed      <= next_linkLed;
      duplexLed    <= next_duplexLed;
    end
  end

  // ****************************************
  // Mode and power-down outputs
  // ****************************************
  wire next_outEnable;
  wire next_isolate;

  assign next_outEnable = !pdNow && !inReset;
  assign next_isolate   = pdNow || inReset;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ledOe          <= 1'b0;
      lineTxOe       <= 1'b0;
      miiIsolate     <= 1'b1;
      powerDown      <= 1'b0;
      resetDone      <= 1'b0;
      autonegEnable  <= 1'b0;
      lineCodeBypass <= 1'b0;
      loopback       <= 1'b0;
      advertiseMode  <= 2'b00;
    end else begin
      powerDown      <= pdNow;
      ledOe          <= next_outEnable;
      lineTxOe       <= next_outEnable;
      miiIsolate     <= next_isolate;
      resetDone      <= !inReset;
      autonegEnable  <= ctrlReg[plsr_pkg::AUTONEG_BIT];
      lineCodeBypass <= ctrlReg[plsr_pkg::BYPASS_BIT];
      loopback       <= ctrlReg[plsr_pkg::LOOPBACK_BIT];
      advertiseMode  <= advNow;
    end
  end

endmodule

// file: verilog/plsr_pkg.sv
// Package with register map, field positions, reset values and timing counts.
// Assumes a 40 MHz core clock and a 32-bit Avalon-MM register slave.
package plsr_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned RESET_MIN_US    = 1000;
  // Internal reset must last more than 1 ms: round down, plus one cycle
  localparam int unsigned RESET_CYCLES    = (RESET_MIN_US * 1000) / CLK_PERIOD_NS + 1;
  localparam int unsigned ACT_BLINK_HZ    = 10;
  localparam int unsigned COL_BLINK_HZ    = 20;
  // Half period of each blink, in cycles
  localparam int unsigned ACT_HALF_CYCLES = CLK_HZ / (2 * ACT_BLINK_HZ);
  localparam int unsigned COL_HALF_CYCLES = CLK_HZ / (2 * COL_BLINK_HZ);

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STRAP_OFFSET  = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int unsigned LOOPBACK_BIT   = 14;
  localparam int unsigned AUTONEG_BIT    = 12;
  localparam int unsigned POWER_DOWN_BIT = 11;
  localparam int unsigned BYPASS_BIT     = 1;
  localparam logic [31:0] CTRL_RESET     = 32'h00000000;

  // ****************************************
  // Strap status register fields
  // ****************************************
  localparam int unsigned STRAP_SPEED_LOW  = 7;
  localparam int unsigned STRAP_ACTIVITY   = 6;
  localparam int unsigned STRAP_LINK       = 5;
  localparam int unsigned STRAP_DUPLEX     = 4;
  localparam int unsigned STRAP_SPEED_HIGH = 3;

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int unsigned STAT_ADV_LSB   = 0;
  localparam int unsigned STAT_PWRDN     = 4;
  localparam int unsigned STAT_RST_DONE  = 5;

endpackage
